// [vstc_top.sv]
/*
 * Supply trim controller: conditions buttons and code switches, captures
 * voltage-id codes, drives open-drain supply enables and status LEDs,
 * selects margin profiles, sequences the restart power-down, and offers
 * control and status over a classic Wishbone slave.
 * Assumes pull-ups on every open-drain net and one 25 MHz clock.
 */
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
// How it works
// [R1] Holding the first button raises both trim targets by five percent.
// [R2] Holding the second button lowers both trim targets by five percent.
// [R3] Buttons read low when pressed; none or both pressed means nominal.
// [R4] Restart drops the DC-DC enable first, then the regulator enable.
// [R5] After power-down the sequencer returns to its initial state and reruns.
// [R6] Heartbeat LED completes one on/off cycle every 500 ms.
// [R7] After reset or restart the regulator stays off and dark until loaded.
// [R8] Second button press captures the regulator code switches.
// [R9] Outside party presents regulator codes 0 or 10 to 15 only.
// [R10] Regulator code zero disables and darkens; nonzero enables and lights.
// [R11] First button press captures the DC-DC code switches.
// [R12] Outside party presents DC-DC codes 0 to 9 only.
// [R13] DC-DC code zero disables and darkens; nonzero enables and lights.
// [R14] One sixteen-entry table maps codes to targets for both supplies.
// [R15] Table output is the target the trim loop compares against.
// [R16] Switch up reads one; the first switch is the code's LSB.
// [R17] Sequencer LEDs are open-drain, pulled low to light.
// [R18] Each supply enable has its own open-drain output.
// [R19] Board LEDs are driven low for on and high for off.
// [R20] Inputs are synchronised, debounced, and a press counts once.
// [R21] Captured codes hold until the next press or a restart.
`timescale 1ns/10ps
module vstc_top
	import vstc_pkg::*;
#(
	parameter int DEB_CYCLES  = DEBOUNCE_CYCLES,
	parameter int HB_CYCLES   = HB_HALF_CYCLES,
	parameter int STEP_CYCLES = PWRDN_STEP_CYCLES,
	parameter int ADR_W       = 8
)(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	// Buttons, active low, and code switches
	input  wire logic              first_pushbutton_n_i,
	input  wire logic              second_pushbutton_n_i,
	input  wire logic              restart_button_n_i,
	input  wire logic [CODE_W-1:0] dcdc_code_switches_i,
	input  wire logic [CODE_W-1:0] regulator_code_switches_i,
	// Open-drain sequencer LEDs
	input  wire logic [3:0]        seq_led_i,
	output logic      [3:0]        seq_led_o,
	output logic      [3:0]        seq_led_oe_o,
	// Open-drain supply enables
	input  wire logic [1:0]        supply_enable_i,
	output logic      [1:0]        supply_enable_o,
	output logic      [1:0]        supply_enable_oe_o,
	// Push-pull board LEDs and trim targets
	output logic      [7:0]        board_led_n_o,
	output logic      [TARGET_W-1:0] dcdc_trim_target_o,
	output logic      [TARGET_W-1:0] reg_trim_target_o,
	output vstc_profile_t          trim_profile_o
);
	localparam int N_IN   = 3 + 2 * CODE_W;
	localparam int STEP_W = $clog2(STEP_CYCLES + 1);
	localparam int HB_W   = $clog2(HB_CYCLES + 1);
	// Buttons idle high, switches reset low
	localparam logic [N_IN-1:0] IN_RST = {{(2 * CODE_W){1'b0}}, 3'b111};

	typedef struct packed {
		vstc_seq_t           seq;
		logic [STEP_W-1:0]   step_cnt;
		logic [HB_W-1:0]     hb_cnt;
		logic                hb;
		logic [CODE_W-1:0]   dcdc_code;
		logic [CODE_W-1:0]   reg_code;
		vstc_profile_t       profile;
		logic [TARGET_W-1:0] dcdc_tgt;
		logic [TARGET_W-1:0] reg_tgt;
		logic [7:0]          board_led_n;
		logic                ack;
		logic [31:0]         rdata;
		logic                soft_restart;
		logic [2:0][5:0]     sense_sync;
		logic [5:0]          sense;
	} vstc_top_state_t;

	vstc_top_state_t st;
	vstc_top_state_t next_st;

	logic [N_IN-1:0]     raw_in;
	logic [N_IN-1:0]     in_level;
	logic [N_IN-1:0]     in_fall;
	logic [TARGET_W-1:0] dcdc_lut;
	logic [TARGET_W-1:0] reg_lut;
	logic                first_held;
	logic                second_held;
	logic                restart_req;
	logic                wb_req;
	logic [7:0]          wb_off;

	if (DEB_CYCLES < 1 || HB_CYCLES < 1 || STEP_CYCLES < 1 || ADR_W < 4 || ADR_W > 8)
	begin : g_chk
		$error("vstc_top: counts must be at least 1 and ADR_W within 4 to 8");
	end

	// Pin order: buttons in bits 2:0, DC-DC code, then regulator code
	assign raw_in = {regulator_code_switches_i, dcdc_code_switches_i,
		restart_button_n_i, second_pushbutton_n_i, first_pushbutton_n_i};

	// One conditioner per pin [R20]
	for (genvar i = 0; i < N_IN; i++)
	begin : g_in
		vstc_debounce #(
			.CYCLES    (DEB_CYCLES),
			.RST_LEVEL (IN_RST[i])
		) u_deb (
			.clk_i   (clk_i),
			.rst_i   (rst_i),
			.pin_i   (raw_in[i]),
			.level_o (in_level[i]),
			.fall_o  (in_fall[i])
		);
	end

	// Pressed means low on the pin [R3]
	assign first_held  = ~in_level[0];
	assign second_held = ~in_level[1];
	assign restart_req = in_fall[2] | st.soft_restart;

	// Both supplies share the same table [R14]
	vstc_target_lut u_lut_dcdc (
		.code_i    (st.dcdc_code),
		.profile_i (st.profile),
		.target_o  (dcdc_lut)
	);

	vstc_target_lut u_lut_reg (
		.code_i    (st.reg_code),
		.profile_i (st.profile),
		.target_o  (reg_lut)
	);

	assign wb_req = wb_cyc_i & wb_stb_i & ~st.ack;
	assign wb_off = 8'(wb_adr_i);

	// Next-state logic for sequencer, capture, heartbeat and bus
	always_comb
	begin
		next_st              = st;
		next_st.soft_restart = 1'b0;

		// Free-running heartbeat, toggled each half period [R6]
		if (st.hb_cnt == HB_W'(HB_CYCLES - 1))
		begin
			next_st.hb_cnt = '0;
			next_st.hb     = ~st.hb;
		end
		else
		begin
			next_st.hb_cnt = st.hb_cnt + HB_W'(1);
		end

		// Margin profile follows held buttons; both held is nominal [R1] [R2] [R3]
		if (first_held && !second_held)
			next_st.profile = PROF_UP;
		else if (second_held && !first_held)
			next_st.profile = PROF_DOWN;
		else
			next_st.profile = PROF_NOMINAL;

		case (st.seq)
			SEQ_RUN:
			begin
				// Switch bits taken as read, bit 0 is the first switch [R16]
				if (in_fall[0])
					next_st.dcdc_code = in_level[3 +: CODE_W]; // [R11] [R21]
				if (in_fall[1])
					next_st.reg_code = in_level[3 + CODE_W +: CODE_W]; // [R8] [R21]
				if (restart_req)
				begin
					next_st.seq       = SEQ_DCDC_DOWN;
					next_st.dcdc_code = RST_CODE; // DC-DC goes down first [R4]
					next_st.step_cnt  = '0;
				end
			end
			SEQ_DCDC_DOWN:
			begin
				if (st.step_cnt == STEP_W'(STEP_CYCLES - 1))
				begin
					next_st.seq      = SEQ_REG_DOWN;
					next_st.reg_code = RST_CODE; // Regulator only after the gap [R4]
					next_st.step_cnt = '0;
				end
				else
				begin
					next_st.step_cnt = st.step_cnt + STEP_W'(1);
				end
			end
			SEQ_REG_DOWN:
			begin
				if (st.step_cnt == STEP_W'(STEP_CYCLES - 1))
				begin
					next_st.seq      = SEQ_RUN; // Back to the start, codes empty [R5] [R7]
					next_st.step_cnt = '0;
				end
				else
				begin
					next_st.step_cnt = st.step_cnt + STEP_W'(1);
				end
			end
			default:
			begin
				next_st.seq = SEQ_RUN;
			end
		endcase

		// Targets registered so the trim loop sees clean values [R15]
		next_st.dcdc_tgt    = dcdc_lut;
		next_st.reg_tgt     = reg_lut;
		next_st.board_led_n = ~{st.reg_code, st.dcdc_code}; // Low lights a board LED [R19]

		// Sensed nets are pins: three flops, a bit moves once stages two and three agree
		next_st.sense_sync = {st.sense_sync[1:0], supply_enable_i, seq_led_i};
		next_st.sense      = (st.sense & (st.sense_sync[1] ^ st.sense_sync[2]))
			| (st.sense_sync[2] & ~(st.sense_sync[1] ^ st.sense_sync[2]));

		// Bus answers one cycle after the request, unmapped reads zero
		next_st.ack   = wb_req;
		next_st.rdata = '0;
		if (wb_req)
		begin
			if (wb_we_i && wb_off == REG_CTRL && wb_sel_i[0])
				next_st.soft_restart = wb_dat_i[CTRL_RESTART_BIT];
			if (!wb_we_i)
			begin
				case (wb_off)
					REG_STATUS:
					begin
						next_st.rdata[ST_DCDC_CODE_LSB +: CODE_W] = st.dcdc_code;
						next_st.rdata[ST_REG_CODE_LSB +: CODE_W]  = st.reg_code;
						next_st.rdata[ST_DCDC_EN_BIT]             = |st.dcdc_code;
						next_st.rdata[ST_REG_EN_BIT]              = |st.reg_code;
						next_st.rdata[ST_PROFILE_LSB +: 2]        = st.profile;
						next_st.rdata[ST_SEQ_LSB +: 2]            = st.seq;
						next_st.rdata[ST_HB_BIT]                  = st.hb;
						next_st.rdata[ST_LED_SENSE_LSB +: 4]      = st.sense[3:0];
						next_st.rdata[ST_EN_SENSE_LSB +: 2]       = st.sense[5:4];
					end
					REG_TARGETS:
					begin
						next_st.rdata[TG_DCDC_LSB +: TARGET_W] = st.dcdc_tgt;
						next_st.rdata[TG_REG_LSB +: TARGET_W]  = st.reg_tgt;
					end
					default:
					begin
						next_st.rdata = '0;
					end
				endcase
			end
		end
	end

	// Reset leaves both supplies off with empty codes [R7]
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st.seq          <= SEQ_RUN;
			st.step_cnt     <= '0;
			st.hb_cnt       <= '0;
			st.hb           <= 1'b0;
			st.dcdc_code    <= RST_CODE;
			st.reg_code     <= RST_CODE;
			st.profile      <= PROF_NOMINAL;
			st.dcdc_tgt     <= '0;
			st.reg_tgt      <= '0;
			st.board_led_n  <= 8'hff;
			st.ack          <= 1'b0;
			st.rdata        <= '0;
			st.soft_restart <= 1'b0;
			st.sense_sync   <= '0;
			st.sense        <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	// Open-drain nets only ever pull low; a lit LED is a driven pin [R17]
	assign seq_led_o                    = 4'h0;
	assign seq_led_oe_o[LED_HEARTBEAT]  = st.hb;                    // [R6]
	assign seq_led_oe_o[LED_MARGIN]     = st.profile != PROF_NOMINAL;
	assign seq_led_oe_o[LED_DCDC]       = |st.dcdc_code;           // [R13]
	assign seq_led_oe_o[LED_REG]        = |st.reg_code;            // [R10]

	// Enable released high through its pull-up, held low while off [R18]
	assign supply_enable_o              = 2'h0;
	assign supply_enable_oe_o[EN_REG]   = ~|st.reg_code;           // [R10]
	assign supply_enable_oe_o[EN_DCDC]  = ~|st.dcdc_code;          // [R13]

	assign board_led_n_o      = st.board_led_n;
	assign dcdc_trim_target_o = st.dcdc_tgt;
	assign reg_trim_target_o  = st.reg_tgt;
	assign trim_profile_o     = st.profile;
	assign wb_dat_o           = st.rdata;
	assign wb_ack_o           = st.ack;

endmodule : vstc_top

// [vstc_pkg.sv]
/*
 * Shared constants for the supply trim controller: clock rate, derived
 * timing counts, the code-to-target table, register offsets and fields.
 * Assumes a single 25 MHz system clock.
 */
package vstc_pkg;

	// Clock and derived timing
	localparam int CLK_HZ            = 25_000_000;
	localparam int DEBOUNCE_MS       = 10;
	localparam int DEBOUNCE_CYCLES   = CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam int HB_PERIOD_MS      = 500;
	localparam int HB_HALF_CYCLES    = CLK_HZ / 1000 * HB_PERIOD_MS / 2;
	localparam int PWRDN_STEP_US     = 1000;
	localparam int PWRDN_STEP_CYCLES = CLK_HZ / 1_000_000 * PWRDN_STEP_US;

	// Code and target widths
	localparam int CODE_W   = 4;
	localparam int TARGET_W = 12;
	localparam logic [TARGET_W-1:0] MARGIN_DIV = 12'h014; // 5 percent is one twentieth
	localparam logic [CODE_W-1:0]   RST_CODE   = 4'h0;

	// Shared code-to-target table, entry 0 first
	localparam logic [TARGET_W-1:0] CODE_TARGETS [16] = '{
		12'h000, 12'h23a, 12'h244, 12'h24e, 12'h253, 12'h258, 12'h25d, 12'h262,
		12'h26c, 12'h276, 12'h4b0, 12'h4c9, 12'h4e2, 12'h4fb, 12'h514, 12'h51e
	};

	// Register byte offsets
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_STATUS  = 8'h04;
	localparam logic [7:0] REG_TARGETS = 8'h08;

	// Field positions
	localparam int CTRL_RESTART_BIT = 0;
	localparam int ST_DCDC_CODE_LSB = 0;
	localparam int ST_REG_CODE_LSB  = 4;
	localparam int ST_DCDC_EN_BIT   = 8;
	localparam int ST_REG_EN_BIT    = 9;
	localparam int ST_PROFILE_LSB   = 10;
	localparam int ST_SEQ_LSB       = 12;
	localparam int ST_HB_BIT        = 14;
	localparam int ST_LED_SENSE_LSB = 15;
	localparam int ST_EN_SENSE_LSB  = 19;
	localparam int TG_DCDC_LSB      = 0;
	localparam int TG_REG_LSB       = 16;

	// Sequencer LED lanes
	localparam int LED_HEARTBEAT = 0;
	localparam int LED_MARGIN    = 1;
	localparam int LED_DCDC      = 2;
	localparam int LED_REG       = 3;

	// Supply enable lanes
	localparam int EN_REG  = 0;
	localparam int EN_DCDC = 1;

	typedef enum logic [1:0] {PROF_NOMINAL, PROF_UP, PROF_DOWN} vstc_profile_t;
	typedef enum logic [1:0] {SEQ_RUN, SEQ_DCDC_DOWN, SEQ_REG_DOWN} vstc_seq_t;

endpackage : vstc_pkg

// [vstc_debounce.sv]
/*
 * One input conditioner: three-stage synchroniser and a stability filter.
 * Assumes an asynchronous pin input and a synchronous active-high reset.
 */
`timescale 1ns/10ps
module vstc_debounce
	import vstc_pkg::*;
#(
	parameter int   CYCLES    = DEBOUNCE_CYCLES,
	parameter logic RST_LEVEL = 1'b1
)(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic pin_i,
	output logic      level_o,
	output logic      fall_o
);
	localparam int CNT_W = $clog2(CYCLES + 1);

	typedef struct packed {
		logic [2:0]       sync;
		logic [CNT_W-1:0] cnt;
		logic             level;
		logic             fall;
	} vstc_deb_state_t;

	vstc_deb_state_t st;
	vstc_deb_state_t next_st;

	if (CYCLES < 1)
	begin : g_chk
		$error("vstc_debounce: CYCLES must be at least 1");
	end

	// Second and third stages must agree; the first stage feeds only the second
	always_comb
	begin
		next_st      = st;
		next_st.sync = {st.sync[1:0], pin_i};
		next_st.fall = 1'b0;
		if (st.sync[1] == st.sync[2] && st.sync[2] != st.level)
		begin
			if (st.cnt == CNT_W'(CYCLES - 1))
			begin
				next_st.level = st.sync[2];
				next_st.fall  = st.level & ~st.sync[2]; // One strobe per press [R20]
				next_st.cnt   = '0;
			end
			else
			begin
				next_st.cnt = st.cnt + CNT_W'(1);
			end
		end
		else
		begin
			next_st.cnt = '0; // Any bounce restarts the wait [R20]
		end
	end

	// Reset to the idle level so no false press appears
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st.sync  <= {3{RST_LEVEL}};
			st.cnt   <= '0;
			st.level <= RST_LEVEL;
			st.fall  <= 1'b0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign level_o = st.level;
	assign fall_o  = st.fall;

endmodule : vstc_debounce

// [vstc_target_lut.sv]
/*
 * Code-to-target lookup with margin offset, one per supply.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/10ps
module vstc_target_lut
	import vstc_pkg::*;
(
	input  wire logic [CODE_W-1:0]   code_i,
	input  wire vstc_profile_t       profile_i,
	output logic      [TARGET_W-1:0] target_o
);
	logic [TARGET_W-1:0] base;
	logic [TARGET_W-1:0] delta;

	// Shared table gives the nominal ADC target [R14] [R15]
	always_comb
	begin
		base  = CODE_TARGETS[code_i];
		delta = base / MARGIN_DIV;
		case (profile_i)
			PROF_UP:   target_o = base + delta; // Raise by 5% [R1]
			PROF_DOWN: target_o = base - delta; // Lower by 5% [R2]
			default:   target_o = base;         // Plain closed-loop trim [R3]
		endcase
	end

endmodule : vstc_target_lut

// [vstc_assertions.sv]
/* Port checker for the supply trim controller, bound to vstc_top.
   Assumes one clock, synchronous reset, heartbeat HB_CYCLES from the bind. */
`timescale 1ns/10ps
module vstc_assertions
	import vstc_pkg::*;
#(
	parameter int HB_CYCLES = HB_HALF_CYCLES
)(
	input wire logic                clk_i,
	input wire logic                rst_i,
	input wire logic                wb_cyc_i,
	input wire logic                wb_stb_i,
	input wire logic                wb_ack_o,
	input wire logic [31:0]         wb_dat_o,
	input wire logic [3:0]          seq_led_o,
	input wire logic [3:0]          seq_led_oe_o,
	input wire logic [1:0]          supply_enable_o,
	input wire logic [1:0]          supply_enable_oe_o,
	input wire logic [TARGET_W-1:0] dcdc_trim_target_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Cycles since the heartbeat last moved; all ones means not yet judged
	logic [7:0] hb_cnt;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			hb_cnt <= 8'hff;
		else if ($changed(seq_led_oe_o[LED_HEARTBEAT]))
			hb_cnt <= 8'h00;
		else if (hb_cnt != 8'hff)
			hb_cnt <= hb_cnt + 8'h01;
	end

	chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged next cycle");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	chk_led_drain: assert property (seq_led_o == 4'h0)
		else $error("led pin driven high");
	chk_en_drain: assert property (supply_enable_o == 2'h0)
		else $error("enable pin driven high");
	chk_hb_period: assert property ($changed(seq_led_oe_o[LED_HEARTBEAT]) && hb_cnt != 8'hff
		|-> hb_cnt == 8'(HB_CYCLES - 1))
		else $error("heartbeat half period wrong");
	chk_dcdc_first: assert property ($rose(supply_enable_oe_o[EN_REG])
		|-> $past(supply_enable_oe_o[EN_DCDC]))
		else $error("regulator dropped before dcdc");
	chk_dcdc_led: assert property (seq_led_oe_o[LED_DCDC] == !supply_enable_oe_o[EN_DCDC])
		else $error("dcdc led disagrees with enable");
	chk_reg_led: assert property (seq_led_oe_o[LED_REG] == !supply_enable_oe_o[EN_REG])
		else $error("regulator led disagrees with enable");
	chk_off_target: assert property (supply_enable_oe_o[EN_DCDC] [*3]
		|-> dcdc_trim_target_o == 12'h000)
		else $error("dcdc off but target nonzero");
endmodule : vstc_assertions

bind vstc_top vstc_assertions #(.HB_CYCLES(HB_CYCLES)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .seq_led_o(seq_led_o),
	.seq_led_oe_o(seq_led_oe_o), .supply_enable_o(supply_enable_o),
	.supply_enable_oe_o(supply_enable_oe_o), .dcdc_trim_target_o(dcdc_trim_target_o)
);

// [vstc_board.sv]
/* Board model: bouncing push-buttons with pull-ups, pulled-up LED and
   enable nets. Assumes the bench calls its tasks right after an edge. */
`timescale 1ns/10ps
module vstc_board
(
	input  wire logic       clk_i,
	input  wire logic [3:0] seq_led_oe_i,
	input  wire logic [1:0] supply_enable_oe_i,
	output logic      [2:0] button_n_o,
	output logic      [3:0] seq_led_net_o,
	output logic      [1:0] supply_enable_net_o
);
	// Released nets float up, an enabled drain pulls low
	assign seq_led_net_o       = ~seq_led_oe_i;
	assign supply_enable_net_o = ~supply_enable_oe_i;

	// Buttons rest high on their pull-ups
	initial
	begin
		button_n_o = 3'h7;
	end

	// Press with one short bounce, then hold long enough to be captured
	task automatic hold_down(input int b);
		@(posedge clk_i);
		button_n_o[b] <= 1'b0;
		@(posedge clk_i);
		button_n_o[b] <= 1'b1;
		@(posedge clk_i);
		button_n_o[b] <= 1'b0;
		repeat (16) @(posedge clk_i);
	endtask : hold_down

	// Release and let the filter see it
	task automatic let_go(input int b);
		button_n_o[b] <= 1'b1;
		repeat (20) @(posedge clk_i);
	endtask : let_go
endmodule : vstc_board

// [test_vid_supply_trim_control.sv]
/* Self-checking bench for vstc_top with short debounce, heartbeat, step.
   Assumes vstc_board and the bound checker are compiled alongside. */
`timescale 1ns/10ps
`define CHK(what, exp, got) \
	begin \
		check_count++; \
		if ((got) !== (exp)) \
		begin \
			n_mismatch++; \
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got); \
		end \
	end
module test_vid_supply_trim_control
	import vstc_pkg::*;
;
	localparam logic [TARGET_W-1:0] EXP_TGT [16] = '{12'h000, 12'h23a, 12'h244, 12'h24e,
		12'h253, 12'h258, 12'h25d, 12'h262, 12'h26c, 12'h276, 12'h4b0, 12'h4c9,
		12'h4e2, 12'h4fb, 12'h514, 12'h51e};
	logic                clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]          wb_adr_i, board_led_n_o;
	logic [31:0]         wb_dat_i, wb_dat_o, rd;
	logic [3:0]          seq_led_i, seq_led_o, seq_led_oe_o, dcdc_sw, reg_sw, wb_sel_i;
	logic [1:0]          supply_enable_i, supply_enable_o, supply_enable_oe_o;
	logic [2:0]          btn_n;
	logic [TARGET_W-1:0] dcdc_trim_target_o, reg_trim_target_o;
	vstc_profile_t       trim_profile_o;
	int                  n_mismatch = 0, check_count = 0;

	vstc_top #(.DEB_CYCLES(4), .HB_CYCLES(8), .STEP_CYCLES(4)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .first_pushbutton_n_i(btn_n[0]),
		.second_pushbutton_n_i(btn_n[1]), .restart_button_n_i(btn_n[2]),
		.dcdc_code_switches_i(dcdc_sw), .regulator_code_switches_i(reg_sw),
		.seq_led_i(seq_led_i), .seq_led_o(seq_led_o), .seq_led_oe_o(seq_led_oe_o),
		.supply_enable_i(supply_enable_i), .supply_enable_o(supply_enable_o),
		.supply_enable_oe_o(supply_enable_oe_o), .board_led_n_o(board_led_n_o),
		.dcdc_trim_target_o(dcdc_trim_target_o), .reg_trim_target_o(reg_trim_target_o),
		.trim_profile_o(trim_profile_o));
	vstc_board board (.clk_i(clk_i), .seq_led_oe_i(seq_led_oe_o),
		.supply_enable_oe_i(supply_enable_oe_o), .button_n_o(btn_n),
		.seq_led_net_o(seq_led_i), .supply_enable_net_o(supply_enable_i));

	// 25 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// One classic cycle; the request holds until ack is sampled
	task automatic wb_rw(input logic we, input logic [7:0] adr, input logic [31:0] wd,
		input logic [3:0] sel);
		int n;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, adr, wd, sel};
		n = 0;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
		if (n >= 50) n_mismatch++;
	endtask : wb_rw

	// Switches settle before the capturing press
	task automatic load(input int b, input logic [3:0] code);
		@(posedge clk_i);
		if (b == 0) dcdc_sw <= code;
		else reg_sw <= code;
		repeat (12) @(posedge clk_i);
		board.hold_down(b);
		board.let_go(b);
	endtask : load

	task automatic t_reset;
		`CHK("enable oe", 2'h3, supply_enable_oe_o)
		`CHK("supply leds", 2'h0, seq_led_oe_o[3:2])
		`CHK("board leds", 8'hff, board_led_n_o)
		`CHK("profile", PROF_NOMINAL, trim_profile_o)
		wb_rw(1'b1, 8'h40, 32'hffff_ffff, 4'hf);
		wb_rw(1'b0, 8'h40, 32'h0, 4'hf);
		`CHK("unmapped", 32'h0, rd)
		$display("t_reset done");
	endtask : t_reset

	// Table entries 1..15: DC-DC takes 1..9, regulator 10..15
	task automatic t_codes;
		int b;
		for (int c = 1; c < 16; c++)
		begin
			b = (c < 10) ? 0 : 1;
			load(b, 4'(c));
			`CHK("target", EXP_TGT[c], b ? reg_trim_target_o : dcdc_trim_target_o)
			`CHK("en oe", 1'b0, supply_enable_oe_o[b ? EN_REG : EN_DCDC])
			`CHK("led oe", 1'b1, seq_led_oe_o[b ? LED_REG : LED_DCDC])
			`CHK("board leds", ~{reg_sw, dcdc_sw}, board_led_n_o)
			wb_rw(1'b0, REG_TARGETS, 32'h0, 4'hf);
			`CHK("read target", EXP_TGT[c], b ? rd[27:16] : rd[11:0])
		end
		dcdc_sw <= 4'h0;
		repeat (20) @(posedge clk_i);
		`CHK("held code", EXP_TGT[9], dcdc_trim_target_o)
		wb_rw(1'b0, REG_STATUS, 32'h0, 4'hf);
		`CHK("status", 12'h3f9, {rd[9:8], rd[7:4], rd[3:0]})
		`CHK("sensed nets", 4'hc, rd[20:17])
		load(0, 4'h0);
		`CHK("dcdc off", 3'h4, {supply_enable_oe_o[EN_DCDC], dcdc_trim_target_o[1:0]})
		load(1, 4'h0);
		`CHK("reg off", 2'h2, {supply_enable_oe_o[EN_REG], seq_led_oe_o[LED_REG]})
		$display("t_codes done");
	endtask : t_codes

	task automatic t_margin;
		load(0, 4'h5);
		load(1, 4'hc);
		board.hold_down(0);
		`CHK("up", PROF_UP, trim_profile_o)
		`CHK("margin led", 1'b1, seq_led_oe_o[LED_MARGIN])
		`CHK("up dcdc", EXP_TGT[5] + EXP_TGT[5] / 20, dcdc_trim_target_o)
		`CHK("up reg", EXP_TGT[12] + EXP_TGT[12] / 20, reg_trim_target_o)
		board.let_go(0);
		board.hold_down(1);
		`CHK("down", PROF_DOWN, trim_profile_o)
		`CHK("down dcdc", EXP_TGT[5] - EXP_TGT[5] / 20, dcdc_trim_target_o)
		`CHK("down reg", EXP_TGT[12] - EXP_TGT[12] / 20, reg_trim_target_o)
		board.hold_down(0);
		`CHK("both held", PROF_NOMINAL, trim_profile_o)
		board.let_go(0);
		board.let_go(1);
		`CHK("nominal", EXP_TGT[5], dcdc_trim_target_o)
		$display("t_margin done");
	endtask : t_margin

	// Both supplies on: restart drops DC-DC, then regulator a step later
	task automatic t_restart;
		int n;
		board.hold_down(2);
		board.let_go(2);
		load(1, 4'hb);
		board.hold_down(2);
		`CHK("both off", 2'h3, supply_enable_oe_o)
		board.let_go(2);
		load(0, 4'h3);
		@(posedge clk_i);
		`CHK("reload", 2'h1, supply_enable_oe_o)
		load(1, 4'hb);
		wb_rw(1'b1, REG_CTRL, 32'h1, 4'he);
		repeat (4) @(posedge clk_i);
		`CHK("lane ignored", 2'h0, supply_enable_oe_o)
		wb_rw(1'b1, REG_CTRL, 32'h1, 4'hf);
		n = 0;
		while (supply_enable_oe_o[EN_DCDC] !== 1'b1 && n < 40) begin @(posedge clk_i); n++; end
		`CHK("reg holds", 1'b0, supply_enable_oe_o[EN_REG])
		n = 0;
		while (supply_enable_oe_o[EN_REG] !== 1'b1 && n < 40) begin @(posedge clk_i); n++; end
		`CHK("step gap", 4, n)
		$display("t_restart done");
	endtask : t_restart

	task automatic t_heartbeat;
		int n;
		logic h;
		h = seq_led_oe_o[LED_HEARTBEAT];
		n = 0;
		while (seq_led_oe_o[LED_HEARTBEAT] === h && n < 40) begin @(posedge clk_i); n++; end
		h = ~h;
		n = 0;
		while (seq_led_oe_o[LED_HEARTBEAT] === h && n < 40) begin @(posedge clk_i); n++; end
		`CHK("half period", 8, n)
		$display("t_heartbeat done");
	endtask : t_heartbeat

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	// Main sequence
	initial
	begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {4'h8, 8'h0, 32'h0};
		{dcdc_sw, reg_sw, wb_sel_i} = 12'h0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (12) @(posedge clk_i);
		t_reset;
		t_codes;
		t_margin;
		t_restart;
		t_heartbeat;
		report_and_stop;
	end

	// Watchdog, well beyond the roughly 1500 cycles the tests need
	initial
	begin
		repeat (30000) @(posedge clk_i);
		n_mismatch++;
		report_and_stop;
	end
endmodule : test_vid_supply_trim_control
